// [src/imub_pkg.sv]
// Purpose: Shared constants and types for the upper interrupt mask bytes.
// Assumes: Register port is synchronous to sys_clk.
// Notes: Bit positions are given per byte, bit 0 being the byte's LSB.
package imub_pkg;

   typedef logic [7:0] imub_addr_t;
   typedef logic [7:0] imub_byte_t;

   // Register offsets on the microprocessor port
   localparam imub_addr_t IMUB_OFS_MIDDLE = 8'h44;
   localparam imub_addr_t IMUB_OFS_HIGH = 8'h45;

   // Reset values: every event starts blocked
   localparam imub_byte_t IMUB_RST_MIDDLE = 8'h00;
   localparam imub_byte_t IMUB_RST_HIGH = 8'h00;

   // Value returned for a read of an unmapped offset
   localparam imub_byte_t IMUB_UNMAPPED_DATA = 8'h00;

   // Middle byte (interrupt bits 15:8)
   localparam int IMUB_MID_OPERATING_MODE = 7;
   localparam int IMUB_MID_MAIN_REF_FAILED = 6;
   localparam int IMUB_MID_INPUT_FOURTEEN = 5;
   localparam int IMUB_MID_INPUT_THIRTEEN = 4;
   localparam int IMUB_MID_INPUT_TWELVE = 3;
   localparam int IMUB_MID_INPUT_ELEVEN = 2;
   localparam int IMUB_MID_INPUT_TEN = 1;
   localparam int IMUB_MID_INPUT_NINE = 0;

   // High byte (interrupt bits 23:16)
   localparam int IMUB_HI_EXTERNAL_SYNC_ALARM = 7;
   localparam int IMUB_HI_SECONDARY_PATH_STATE_CHANGE = 6;
   localparam int IMUB_HI_PHASE_MONITOR_ALARM = 5;
   localparam int IMUB_HI_SECONDARY_PATH_INPUTS_LOST = 4;
   localparam int IMUB_HI_CODED_INPUT_TWO_VIOLATION = 3;
   localparam int IMUB_HI_CODED_INPUT_TWO_SIGNAL_LOSS = 2;
   localparam int IMUB_HI_CODED_INPUT_ONE_VIOLATION = 1;
   localparam int IMUB_HI_CODED_INPUT_ONE_SIGNAL_LOSS = 0;

   // Number of events covered by both bytes
   localparam int IMUB_EVENT_COUNT = 16;

endpackage : imub_pkg

// [src/imub_mask_if.sv]
// Purpose: Carries the write strobe, write data and stored value of one mask byte.
// Assumes: All signals belong to the sys_clk domain.
// Notes: The owner holds the flip-flops; the user decodes and reads.
interface imub_mask_if;
   import imub_pkg::*;

   logic wr_en;
   imub_byte_t wdata;
   imub_byte_t value;

   modport owner (input wr_en, input wdata, output value);
   modport user (output wr_en, output wdata, input value);

endinterface : imub_mask_if

// [src/imub_mask_byte.sv]
// Purpose: One read/write mask byte with a fixed reset value.
// Assumes: wr_en is a single-cycle strobe from the address decode.
// Notes: The new value is visible on value right after the write edge.
module imub_mask_byte
#(
   parameter imub_pkg::imub_byte_t RESET_VALUE = 8'h00
)
(
   input wire logic sys_clk,
   input wire logic arst_n,
   imub_mask_if.owner mask
);
   import imub_pkg::*;

   typedef struct packed
   {
      imub_byte_t value;
   } imub_mask_state_t;

   imub_mask_state_t state_q;
   imub_mask_state_t state_d;

   always_comb
   begin
      state_d = state_q;
      if (mask.wr_en)
      begin
         state_d.value = mask.wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= '{value: RESET_VALUE};
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign mask.value = state_q.value;

endmodule : imub_mask_byte

// [src/imub_event_gate.sv]
// Purpose: Gates pending event flags with their mask bits and merges them into one request.
// Assumes: Pending flags come from logic on sys_clk and are held by their sources.
// Notes: Both outputs are registered, so they trail the inputs by one edge.
module imub_event_gate
#(
   parameter int WIDTH = 16
)
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] pending,
   input wire logic [WIDTH-1:0] enable,
   output logic [WIDTH-1:0] gated,
   output logic request
);
   import imub_pkg::*;

   typedef struct packed
   {
      logic [WIDTH-1:0] gated;
      logic request;
   } imub_gate_state_t;

   imub_gate_state_t state_q;
   imub_gate_state_t state_d;

   always_comb
   begin
      state_d.gated = pending & enable;
      state_d.request = |(pending & enable);
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign gated = state_q.gated;
   assign request = state_q.request;

endmodule : imub_event_gate

// [src/imub_top.sv]
// Purpose: Upper two bytes of the interrupt enable mask and the request they gate.
// Assumes: The microprocessor port is already synchronous to sys_clk; event
//    sources present level flags on sys_clk that stay high until serviced.
// Notes: Reads return data one edge after the strobe; unmapped reads give zero.

// Summary of operation
// - High mask byte is read/write, resets zero.
// - Middle mask byte is read/write, resets zero.
// - Middle bits 4..0 enable inputs 13..9.
// - High bit 7 gates external sync alarm.
// - High bit 6 gates secondary path state change.
// - High bit 5 gates phase monitor alarm.
// - High bit 4 gates secondary path inputs lost.
// - High bit 3 gates coded input two violation.
// - High bit 2 gates coded input two loss.
// - High bit 1 gates coded input one violation.
// - High bit 0 gates coded input one loss.
// - Middle bits 7,6 gate mode change, reference failure.
// - Middle bit 5 gates input fourteen.
module imub_top
(
   input wire logic sys_clk,
   input wire logic arst_n,
   // Microprocessor register port
   input wire imub_pkg::imub_addr_t reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire imub_pkg::imub_byte_t reg_wdata,
   output imub_pkg::imub_byte_t reg_rdata,
   output logic reg_rd_valid,
   // Pending event flags for interrupt bits 15:8
   input wire logic operating_mode_change,
   input wire logic main_ref_failure,
   input wire logic input_fourteen,
   input wire logic input_thirteen,
   input wire logic input_twelve,
   input wire logic input_eleven,
   input wire logic input_ten,
   input wire logic input_nine,
   // Pending event flags for interrupt bits 23:16
   input wire logic external_sync_alarm,
   input wire logic secondary_path_state_change,
   input wire logic phase_monitor_alarm,
   input wire logic secondary_path_inputs_lost,
   input wire logic coded_input_two_violation,
   input wire logic coded_input_two_signal_loss,
   input wire logic coded_input_one_violation,
   input wire logic coded_input_one_signal_loss,
   // Mask state and gated results
   output imub_pkg::imub_byte_t event_enable_middle,
   output imub_pkg::imub_byte_t event_enable_high,
   output imub_pkg::imub_byte_t masked_events_middle,
   output imub_pkg::imub_byte_t masked_events_high,
   output logic irq_req
);
   import imub_pkg::*;

   typedef struct packed
   {
      imub_byte_t rdata;
      logic rd_valid;
   } imub_port_state_t;

   imub_port_state_t state_q;
   imub_port_state_t state_d;

   imub_mask_if mid_if ();
   imub_mask_if high_if ();

   logic sel_middle;
   logic sel_high;
   imub_byte_t pending_middle;
   imub_byte_t pending_high;
   logic [IMUB_EVENT_COUNT-1:0] pending_all;
   logic [IMUB_EVENT_COUNT-1:0] enable_all;
   logic [IMUB_EVENT_COUNT-1:0] gated_all;
   logic gate_request;

   // Address decode; only the two mask offsets are mapped here
   assign sel_middle = (reg_addr == IMUB_OFS_MIDDLE);
   assign sel_high = (reg_addr == IMUB_OFS_HIGH);

   // Writes land in the byte on the same edge that samples the strobe
   assign mid_if.wr_en = reg_wr && sel_middle;
   assign mid_if.wdata = reg_wdata;
   assign high_if.wr_en = reg_wr && sel_high;
   assign high_if.wdata = reg_wdata;

   imub_mask_byte
   #(
      .RESET_VALUE(IMUB_RST_MIDDLE)
   )
   u_mask_middle
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .mask(mid_if.owner)
   );

   imub_mask_byte
   #(
      .RESET_VALUE(IMUB_RST_HIGH)
   )
   u_mask_high
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .mask(high_if.owner)
   );

   // Place each event on the bit that its mask bit occupies
   always_comb
   begin
      pending_middle = '0;
      pending_middle[IMUB_MID_OPERATING_MODE] = operating_mode_change;
      pending_middle[IMUB_MID_MAIN_REF_FAILED] = main_ref_failure;
      pending_middle[IMUB_MID_INPUT_FOURTEEN] = input_fourteen;
      pending_middle[IMUB_MID_INPUT_THIRTEEN] = input_thirteen;
      pending_middle[IMUB_MID_INPUT_TWELVE] = input_twelve;
      pending_middle[IMUB_MID_INPUT_ELEVEN] = input_eleven;
      pending_middle[IMUB_MID_INPUT_TEN] = input_ten;
      pending_middle[IMUB_MID_INPUT_NINE] = input_nine;
   end

   always_comb
   begin
      pending_high = '0;
      pending_high[IMUB_HI_EXTERNAL_SYNC_ALARM] = external_sync_alarm;
      pending_high[IMUB_HI_SECONDARY_PATH_STATE_CHANGE] = secondary_path_state_change;
      pending_high[IMUB_HI_PHASE_MONITOR_ALARM] = phase_monitor_alarm;
      pending_high[IMUB_HI_SECONDARY_PATH_INPUTS_LOST] = secondary_path_inputs_lost;
      pending_high[IMUB_HI_CODED_INPUT_TWO_VIOLATION] = coded_input_two_violation;
      pending_high[IMUB_HI_CODED_INPUT_TWO_SIGNAL_LOSS] = coded_input_two_signal_loss;
      pending_high[IMUB_HI_CODED_INPUT_ONE_VIOLATION] = coded_input_one_violation;
      pending_high[IMUB_HI_CODED_INPUT_ONE_SIGNAL_LOSS] = coded_input_one_signal_loss;
   end

   // High byte above middle byte, as in the 24-bit interrupt word
   assign pending_all = {pending_high, pending_middle};
   assign enable_all = {high_if.value, mid_if.value};

   // A one in a mask bit lets its event through; zero blocks it
   imub_event_gate
   #(
      .WIDTH(IMUB_EVENT_COUNT)
   )
   u_gate
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .pending(pending_all),
      .enable(enable_all),
      .gated(gated_all),
      .request(gate_request)
   );

   // Read path: registered so rdata never glitches with the address
   always_comb
   begin
      state_d = state_q;
      state_d.rd_valid = reg_rd;
      if (reg_rd)
      begin
         if (sel_middle)
         begin
            state_d.rdata = mid_if.value;
         end
         else if (sel_high)
         begin
            state_d.rdata = high_if.value;
         end
         else
         begin
            state_d.rdata = IMUB_UNMAPPED_DATA;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= '{rdata: IMUB_UNMAPPED_DATA, rd_valid: 1'b0};
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign reg_rdata = state_q.rdata;
   assign reg_rd_valid = state_q.rd_valid;

   assign event_enable_middle = mid_if.value;
   assign event_enable_high = high_if.value;
   // Gated flags let software see which enabled event holds the request
   assign masked_events_middle = gated_all[7:0];
   assign masked_events_high = gated_all[15:8];
   assign irq_req = gate_request;

endmodule : imub_top

// [testbench/imub_sva.sv]
// Purpose: Port-level checks of the upper mask bytes and the request they gate.
// Assumes: Single sys_clk domain; bound to imub_top.
// Notes: Pending flags are not watched; gating is judged from mask history.
module imub_sva
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire imub_pkg::imub_addr_t reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire imub_pkg::imub_byte_t reg_wdata,
   input wire imub_pkg::imub_byte_t reg_rdata,
   input wire logic reg_rd_valid,
   input wire imub_pkg::imub_byte_t event_enable_middle,
   input wire imub_pkg::imub_byte_t event_enable_high,
   input wire imub_pkg::imub_byte_t masked_events_middle,
   input wire imub_pkg::imub_byte_t masked_events_high,
   input wire logic irq_req
);
   import imub_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   AST_WR_HI: assert property (
      reg_wr && reg_addr == IMUB_OFS_HIGH |=> event_enable_high == $past(reg_wdata))
      else $error("high mask write lost");
   AST_WR_MID: assert property (
      reg_wr && reg_addr == IMUB_OFS_MIDDLE |=> event_enable_middle == $past(reg_wdata))
      else $error("middle mask write lost");
   AST_HOLD_HI: assert property (
      !(reg_wr && reg_addr == IMUB_OFS_HIGH) |=> $stable(event_enable_high))
      else $error("high mask changed without write");
   AST_HOLD_MID: assert property (
      !(reg_wr && reg_addr == IMUB_OFS_MIDDLE) |=> $stable(event_enable_middle))
      else $error("middle mask changed without write");
   AST_RD_VALID: assert property (
      reg_rd_valid == $past(reg_rd))
      else $error("read valid not one cycle after strobe");
   AST_RD_HI: assert property (
      reg_rd && reg_addr == IMUB_OFS_HIGH |=> reg_rdata == $past(event_enable_high))
      else $error("high mask read wrong");
   AST_RD_MID: assert property (
      reg_rd && reg_addr == IMUB_OFS_MIDDLE |=> reg_rdata == $past(event_enable_middle))
      else $error("middle mask read wrong");
   AST_IRQ_OR: assert property (
      irq_req == |{masked_events_high, masked_events_middle})
      else $error("request is not the OR of masked events");
   AST_GATE_HI: assert property (
      (masked_events_high & ~$past(event_enable_high)) == 8'h00)
      else $error("blocked high event passed");
   AST_GATE_MID: assert property (
      (masked_events_middle & ~$past(event_enable_middle)) == 8'h00)
      else $error("blocked middle event passed");
endmodule : imub_sva

// [testbench/imub_top_test.sv]
// Purpose: Register access and event gating test of imub_top.
// Assumes: Inputs change at the falling edge of sys_clk.
// Notes: pend[15:8] feeds the high byte flags, pend[7:0] the middle.
module imub_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   import imub_pkg::*;
   logic sys_clk, arst_n, reg_wr, reg_rd, reg_rd_valid, irq_req;
   imub_addr_t reg_addr;
   imub_byte_t reg_wdata, reg_rdata, en_mid, en_hi, mk_mid, mk_hi;
   imub_byte_t pat [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h3C};
   logic [15:0] pend, e;
   int bad_count, compares;
   imub_top imub_top_i (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid), .operating_mode_change(pend[7]),
      .main_ref_failure(pend[6]), .input_fourteen(pend[5]), .input_thirteen(pend[4]),
      .input_twelve(pend[3]), .input_eleven(pend[2]), .input_ten(pend[1]),
      .input_nine(pend[0]), .external_sync_alarm(pend[15]),
      .secondary_path_state_change(pend[14]), .phase_monitor_alarm(pend[13]),
      .secondary_path_inputs_lost(pend[12]), .coded_input_two_violation(pend[11]),
      .coded_input_two_signal_loss(pend[10]), .coded_input_one_violation(pend[9]),
      .coded_input_one_signal_loss(pend[8]), .event_enable_middle(en_mid),
      .event_enable_high(en_hi), .masked_events_middle(mk_mid),
      .masked_events_high(mk_hi), .irq_req(irq_req));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
      compares++;
      if (s !== x)
      begin
         bad_count++;
         $display("FAIL %s exp %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic wr(input imub_addr_t a, input imub_byte_t d);
      @(negedge sys_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input imub_addr_t a, input imub_byte_t x);
      int n;
      @(negedge sys_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      n = 0;
      while (reg_rd_valid !== 1'b1 && n < 4)
      begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 4)
      begin
         bad_count++;
         end_of_test();
      end
      chk("rdata", {8'h00, reg_rdata}, {8'h00, x});
   endtask : rd
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial
   begin
      repeat (5000) @(posedge sys_clk);
      bad_count++;
      end_of_test();
   end
   initial
   begin
      {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, pend} = '0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      arst_n = 1'b1;
      chk("reset", {en_hi, en_mid}, {IMUB_RST_HIGH, IMUB_RST_MIDDLE});
      rd(IMUB_OFS_MIDDLE, IMUB_RST_MIDDLE);
      rd(IMUB_OFS_HIGH, IMUB_RST_HIGH);
      for (int i = 0; i < 4; i++)
      begin
         wr(IMUB_OFS_MIDDLE, pat[i]);
         wr(IMUB_OFS_HIGH, ~pat[i]);
         rd(IMUB_OFS_MIDDLE, pat[i]);
         rd(IMUB_OFS_HIGH, ~pat[i]);
      end
      // A stray write must not land in either mask byte
      wr(8'h46, 8'hFF);
      rd(8'h46, IMUB_UNMAPPED_DATA);
      chk("masks", {en_hi, en_mid}, {~pat[3], pat[3]});
      for (int i = 0; i < IMUB_EVENT_COUNT; i++)
      begin
         e = 16'h0001 << i;
         wr(IMUB_OFS_MIDDLE, e[7:0]);
         wr(IMUB_OFS_HIGH, e[15:8]);
         @(negedge sys_clk) pend = 16'hFFFF;
         @(negedge sys_clk);
         chk("gated", {mk_hi, mk_mid}, e);
         chk("irq", {15'h0000, irq_req}, 16'h0001);
         @(negedge sys_clk) pend = ~e;
         @(negedge sys_clk);
         chk("gated", {mk_hi, mk_mid}, 16'h0000);
         chk("irq", {15'h0000, irq_req}, 16'h0000);
      end
      pend = 16'hFFFF;
      @(negedge sys_clk);
      wr(IMUB_OFS_HIGH, 8'h00);
      // Mask drop shows on the request one edge after the write
      chk("irq", {15'h0000, irq_req}, 16'h0001);
      @(negedge sys_clk);
      chk("irq", {15'h0000, irq_req}, 16'h0000);
      wr(IMUB_OFS_MIDDLE, 8'hFF);
      // Let the request rise first, so the reset below has something to clear
      @(negedge sys_clk);
      chk("irq", {15'h0000, irq_req}, 16'h0001);
      arst_n = 1'b0;
      @(negedge sys_clk);
      chk("rst2", {en_hi, en_mid}, 16'h0000);
      chk("rst2", {mk_hi, mk_mid}, 16'h0000);
      chk("rst2", {15'h0000, irq_req}, 16'h0000);
      arst_n = 1'b1;
      rd(IMUB_OFS_MIDDLE, IMUB_RST_MIDDLE);
      end_of_test();
   end
endmodule : imub_top_test
bind imub_top imub_sva imub_sva_i (.sys_clk(sys_clk), .arst_n(arst_n),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
   .event_enable_middle(event_enable_middle), .event_enable_high(event_enable_high),
   .masked_events_middle(masked_events_middle), .masked_events_high(masked_events_high),
   .irq_req(irq_req));
